// ===== hdl/ulm_line_modem_ctrl.sv
// Overview of operation
// - divisor_access_select banks c0/c1 onto baud divisor
// - break_send forces zeros from next bit boundary
// - transmit holding cleared on the same clock that break starts
// - break removal resumes at next baud edge
// - force error inverts transmitted parity bit
// - even_parity_sel chooses odd or even parity
// - parity_on adds parity bit and checks it
// - multidrop sends mark/space, checks received space
// - multidrop clears even_parity_sel after each transmitted character
// - polarity bit inverts transmit and receive lines
// - loopback holds txd high, feeds rx internally
// - loopback routes control bits to modem status
// - auxiliary outputs held inactive in every mode, loopback or not
// - rts and dtr pins are inverted bits outside loopback, held high in loopback
// - empty flags stay low while break active
`timescale 1ns/10ps
module ulm_line_modem_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             txd,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        dcd_n,
  input  wire logic        ri_n,
  output logic             rts_n,
  output logic             dtr_n,
  output logic             aux_a_n,
  output logic             aux_b_n
);
  ulm_tx_if tx ();

  logic [7:0]       serial_line_control;
  logic [6:0]       serial_modem_control;
  logic [7:0]       ier;
  logic [7:0]       div_lo;
  logic [7:0]       div_hi;
  logic [15:0]      baud_cnt;
  logic [7:0]       hold;
  logic             hold_full;
  logic [7:0]       rbr;
  logic             dr;
  logic             pe;
  logic             fe;
  logic             oe;
  ulm_pkg::ulm_rx_e rx_state;
  logic [15:0]      rx_cnt;
  logic [7:0]       rx_shift;
  logic [2:0]       rx_idx;
  logic             rx_xor;
  logic             rx_pbit;

  // address decode with divisor banking
  wire logic das      = serial_line_control[ulm_pkg::LC_DAS];
  wire logic sel_data = (io_addr == ulm_pkg::ADDR_DATA);
  wire logic sel_ier  = (io_addr == ulm_pkg::ADDR_IER);
  wire logic wr_thr   = io_wr & sel_data & ~das;
  wire logic wr_dll   = io_wr & sel_data & das;
  wire logic wr_dlm   = io_wr & sel_ier & das;
  wire logic wr_ier   = io_wr & sel_ier & ~das;
  wire logic wr_lctl  = io_wr & (io_addr == ulm_pkg::ADDR_LCTL);
  wire logic wr_mctl  = io_wr & (io_addr == ulm_pkg::ADDR_MCTL);
  wire logic rd_rbr   = io_rd & sel_data & ~das;
  wire logic rd_lsr   = io_rd & (io_addr == ulm_pkg::ADDR_LSR);

  // control field views
  wire logic       brk     = serial_line_control[ulm_pkg::LC_BRK];
  wire logic       parity_error_force     = serial_line_control[ulm_pkg::LC_FPE];
  wire logic       even_parity_sel     = serial_line_control[ulm_pkg::LC_EPS];
  wire logic       par_on  = serial_line_control[ulm_pkg::LC_PAR];
  wire logic [1:0] fmt_len = serial_line_control[1:0];
  wire logic       pol     = serial_modem_control[ulm_pkg::MC_POL];
  wire logic       multidrop_on     = serial_modem_control[ulm_pkg::MC_MDM];
  wire logic       loop    = serial_modem_control[ulm_pkg::MC_LOOP];
  wire logic [15:0] divisor = {div_hi, div_lo};

  // baud generator: one tick per bit time
  wire logic tick = (divisor != 16'h0000) & (baud_cnt == divisor - 16'h0001);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) baud_cnt <= 16'h0000;
    else if (tick || baud_cnt >= divisor) baud_cnt <= 16'h0000;
    else baud_cnt <= baud_cnt + 16'h0001;
  end

  // transmit parity over the active data bits
  wire logic [7:0] len_mask = 8'hff >> (ulm_pkg::LEN_MAX_CODE - {1'b0, fmt_len});
  wire logic data_xor = ^(hold & len_mask);
  wire logic par_norm = even_parity_sel ? data_xor : ~data_xor;
  wire logic par_type = multidrop_on ? even_parity_sel : par_norm;
  assign tx.par_bit  = par_type ^ parity_error_force;
  assign tx.par_on   = par_on;
  assign tx.data     = hold;
  assign tx.fmt_len  = fmt_len;
  assign tx.two_stop = serial_line_control[ulm_pkg::LC_STP];
  assign tx.brk      = brk;
  assign tx.start    = hold_full & tx.ready;

  // status: empty flags held low through any break
  wire logic tx_holding_empty = ~hold_full & ~brk & ~tx.in_break;
  wire logic temt = tx_holding_empty & tx.ready;

  ulm_tx_engine u_tx (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick),
    .tx    (tx)
  );

  // transmit holding register, emptied on break entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold      <= 8'h00;
      hold_full <= 1'b0;
    end else if (wr_thr) begin
      hold      <= io_wdata;  // refill during break is kept for after recovery
      hold_full <= 1'b1;
    end else if (tx.brk_enter || tx.start) begin
      hold_full <= 1'b0;
    end
  end

  // line control with multidrop auto clear of parity select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) serial_line_control <= ulm_pkg::LCTL_RST;
    else if (wr_lctl) serial_line_control <= io_wdata;
    else if (tx.done && multidrop_on) serial_line_control[ulm_pkg::LC_EPS] <= 1'b0;
  end

  // modem control, interrupt enable and divisor latches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_modem_control <= ulm_pkg::MCTL_RST[6:0];
      ier    <= ulm_pkg::IER_RST;
      div_lo <= ulm_pkg::DIV_RST[7:0];
      div_hi <= ulm_pkg::DIV_RST[15:8];
    end else begin
      if (wr_mctl) serial_modem_control <= io_wdata[6:0];  // bit 7 dropped
      if (wr_ier) ier <= io_wdata;
      if (wr_dll) div_lo <= io_wdata;
      if (wr_dlm) div_hi <= io_wdata;
    end
  end

  // line pins: polarity and loopback
  wire logic rx_line = loop ? tx.line : (rxd ^ pol);
  assign txd     = loop ? 1'b1 : (tx.line ^ pol);
  assign rts_n   = loop ? 1'b1 : ~serial_modem_control[ulm_pkg::MC_RTS];
  assign dtr_n   = loop ? 1'b1 : ~serial_modem_control[ulm_pkg::MC_DTR];
  assign aux_a_n = 1'b1;
  assign aux_b_n = 1'b1;

  // modem status sources
  wire logic ms_cts = loop ? serial_modem_control[ulm_pkg::MC_RTS]  : ~cts_n;
  wire logic ms_dsr = loop ? serial_modem_control[ulm_pkg::MC_DTR]  : ~dsr_n;
  wire logic ms_dcd = loop ? serial_modem_control[ulm_pkg::MC_AUXB] : ~dcd_n;
  wire logic ms_ri  = loop ? serial_modem_control[ulm_pkg::MC_AUXA] : ~ri_n;

  // receiver sampling points and completion
  // the first low sample is the start edge; below two clocks a bit it is also the start sample
  wire logic        rx_quick = (divisor[15:1] == 15'h0000);
  wire logic [15:0] rx_half  = {1'b0, divisor[15:1]} - 16'h0001;
  wire logic       rx_sample = (rx_cnt == 16'h0000);
  wire logic       rx_fin    = rx_sample & (rx_state == ulm_pkg::RX_STOP);
  wire logic [2:0] rx_last   = {1'b0, fmt_len} + ulm_pkg::DATA_LAST_MIN;
  wire logic [7:0] rx_data   = rx_shift >> (ulm_pkg::LEN_MAX_CODE - {1'b0, fmt_len});
  wire logic rx_perr = par_on & (multidrop_on ? rx_pbit : (rx_xor ^ rx_pbit ^ ~even_parity_sel));

  // receiver: mid bit sampling from the start edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= ulm_pkg::RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_shift <= 8'h00;
      rx_idx   <= 3'h0;
      rx_xor   <= 1'b0;
      rx_pbit  <= 1'b0;
    end else if (rx_state == ulm_pkg::RX_IDLE) begin
      if (!rx_line) begin
        rx_state <= rx_quick ? ulm_pkg::RX_DATA : ulm_pkg::RX_START;
        rx_cnt   <= rx_quick ? divisor - 16'h0001 : rx_half;  // mid bit, not one bit late
        rx_idx   <= 3'h0;
        rx_xor   <= 1'b0;
      end
    end else if (!rx_sample) begin
      rx_cnt <= rx_cnt - 16'h0001;
    end else begin
      rx_cnt <= divisor - 16'h0001;
      unique case (rx_state)
        ulm_pkg::RX_START: begin
          rx_state <= rx_line ? ulm_pkg::RX_IDLE : ulm_pkg::RX_DATA;
          rx_idx   <= 3'h0;
          rx_xor   <= 1'b0;
        end
        ulm_pkg::RX_DATA: begin
          rx_shift <= {rx_line, rx_shift[7:1]};
          rx_xor   <= rx_xor ^ rx_line;
          rx_idx   <= rx_idx + 3'h1;
          if (rx_idx == rx_last)
            rx_state <= par_on ? ulm_pkg::RX_PAR : ulm_pkg::RX_STOP;
        end
        ulm_pkg::RX_PAR: begin
          rx_pbit  <= rx_line;
          rx_state <= ulm_pkg::RX_STOP;
        end
        ulm_pkg::RX_STOP: rx_state <= ulm_pkg::RX_IDLE;
        default: rx_state <= ulm_pkg::RX_IDLE;
      endcase
    end
  end

  // receive buffer and error flags, a new event wins over a read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rbr <= 8'h00;
      dr  <= 1'b0;
      pe  <= 1'b0;
      fe  <= 1'b0;
      oe  <= 1'b0;
    end else if (rx_fin) begin
      rbr <= rx_data;
      dr  <= 1'b1;
      pe  <= rx_perr | (pe & ~rd_lsr);
      fe  <= ~rx_line | (fe & ~rd_lsr);
      oe  <= (dr & ~rd_rbr) | (oe & ~rd_lsr);
    end else begin
      if (rd_rbr) dr <= 1'b0;
      if (rd_lsr) begin
        pe <= 1'b0;
        fe <= 1'b0;
        oe <= 1'b0;
      end
    end
  end

  // read data selection
  wire logic [7:0] lsr_val = {1'b0, temt, tx_holding_empty, 1'b0, fe, pe, oe, dr};
  wire logic [7:0] msr_val = {ms_dcd, ms_ri, ms_dsr, ms_cts, 4'h0};
  wire logic [7:0] rd_val =
    sel_data ? (das ? div_lo : rbr) :
    sel_ier  ? (das ? div_hi : ier) :
    (io_addr == ulm_pkg::ADDR_LCTL) ? serial_line_control :
    (io_addr == ulm_pkg::ADDR_MCTL) ? {1'b0, serial_modem_control} :
    (io_addr == ulm_pkg::ADDR_LSR)  ? lsr_val :
    (io_addr == ulm_pkg::ADDR_MSR)  ? msr_val : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) io_rdata <= 8'h00;
    else io_rdata <= io_rd ? rd_val : 8'h00;
  end

  // checks on the control behaviour
  a_break_line_low: assert property (@(posedge clock) disable iff (!rst_n)
    (tx.in_break && !loop) |-> txd == pol)
    else $error("txd not held at break level");
  a_break_hold_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (tx.brk_enter && !wr_thr) |=> !hold_full && tx.in_break)
    else $error("holding data survived break entry");
  a_break_flags_low: assert property (@(posedge clock) disable iff (!rst_n)
    (brk || tx.in_break) |-> !lsr_val[ulm_pkg::LS_TX_HOLDING_EMPTY] && !lsr_val[ulm_pkg::LS_TEMT])
    else $error("empty flag high during break");
  a_mdrop_eps_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (tx.done && multidrop_on && !wr_lctl) |=> !serial_line_control[ulm_pkg::LC_EPS])
    else $error("parity select not cleared after multidrop character");
  a_loop_pins_idle: assert property (@(posedge clock) disable iff (!rst_n)
    loop |-> txd && rx_line == tx.line)
    else $error("loopback pin routing wrong");
  a_loop_status_map: assert property (@(posedge clock) disable iff (!rst_n)
    loop |-> msr_val[7:4] == {serial_modem_control[3:2], serial_modem_control[0],
                              serial_modem_control[1]})
    else $error("loopback modem status mapping wrong");
  a_rts_dtr_inverse: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_mctl && !io_wdata[ulm_pkg::MC_LOOP]) |=> rts_n == !$past(io_wdata[1]) &&
                                                 dtr_n == !$past(io_wdata[0]))
    else $error("rts or dtr pin not inverse of control bit");
  a_aux_inactive: assert property (@(posedge clock) disable iff (!rst_n)
    aux_a_n && aux_b_n)
    else $error("auxiliary output active");
  a_mctl_readback: assert property (@(posedge clock) disable iff (!rst_n)
    wr_mctl ##1 !wr_mctl ##1 (io_rd && io_addr == ulm_pkg::ADDR_MCTL && !io_wr) |=>
      io_rdata == {1'b0, $past(io_wdata[6:0], 3)})
    else $error("modem control read back wrong");
  a_divisor_bank: assert property (@(posedge clock) disable iff (!rst_n)
    (io_wr && sel_data && das) |=> div_lo == $past(io_wdata) && !$rose(hold_full))
    else $error("divisor bank write misrouted");
  a_idle_line_level: assert property (@(posedge clock) disable iff (!rst_n)
    (!loop && tx.ready) |-> txd == !pol)
    else $error("idle transmit level ignores polarity");
  a_force_par_flip: assert property (@(posedge clock) disable iff (!rst_n)
    (tx.start && parity_error_force && !multidrop_on) |-> tx.par_bit == (even_parity_sel ^ data_xor))
    else $error("forced parity bit not inverted");
  a_mdrop_par_type: assert property (@(posedge clock) disable iff (!rst_n)
    (tx.start && multidrop_on && !parity_error_force) |-> tx.par_bit == even_parity_sel)
    else $error("multidrop parity bit not mark or space");
  a_rx_space_chk: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_fin && par_on && multidrop_on && rx_pbit) |=> pe)
    else $error("multidrop mark parity not flagged");
endmodule : ulm_line_modem_ctrl

// ===== hdl/ulm_pkg.sv
package ulm_pkg;
  // register addresses on the processor i/o bus
  localparam logic [15:0] ADDR_DATA = 16'h00c0;  // rx buffer, tx holding, divisor low
  localparam logic [15:0] ADDR_IER  = 16'h00c1;  // interrupt enable, divisor high
  localparam logic [15:0] ADDR_LCTL = 16'h00c3;
  localparam logic [15:0] ADDR_MCTL = 16'h00c4;
  localparam logic [15:0] ADDR_LSR  = 16'h00c5;
  localparam logic [15:0] ADDR_MSR  = 16'h00c6;
  // line control fields
  localparam int LC_DAS = 7;
  localparam int LC_BRK = 6;
  localparam int LC_FPE = 5;
  localparam int LC_EPS = 4;
  localparam int LC_PAR = 3;
  localparam int LC_STP = 2;
  // modem control fields
  localparam int MC_POL  = 6;
  localparam int MC_MDM  = 5;
  localparam int MC_LOOP = 4;
  localparam int MC_AUXB = 3;
  localparam int MC_AUXA = 2;
  localparam int MC_RTS  = 1;
  localparam int MC_DTR  = 0;
  localparam logic [7:0] MC_WMASK = 8'h7f;
  // line status fields
  localparam int LS_TEMT = 6;
  localparam int LS_TX_HOLDING_EMPTY = 5;
  localparam int LS_FE   = 3;
  localparam int LS_PE   = 2;
  localparam int LS_OE   = 1;
  localparam int LS_DR   = 0;
  // values after reset
  localparam logic [7:0]  LCTL_RST = 8'h00;
  localparam logic [7:0]  MCTL_RST = 8'h00;
  localparam logic [7:0]  IER_RST  = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  // index of the last data bit for the shortest character
  localparam logic [2:0]  DATA_LAST_MIN = 3'h4;
  localparam logic [2:0]  LEN_MAX_CODE  = 3'h3;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} ulm_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulm_rx_e;
endpackage : ulm_pkg

// ===== hdl/ulm_tx_if.sv
`timescale 1ns/10ps
interface ulm_tx_if;
  logic       start;
  logic [7:0] data;
  logic [1:0] fmt_len;
  logic       two_stop;
  logic       par_on;
  logic       par_bit;
  logic       brk;
  logic       ready;
  logic       done;
  logic       brk_enter;
  logic       in_break;
  logic       line;
  modport ctrl (output start, data, fmt_len, two_stop, par_on, par_bit, brk,
                input  ready, done, brk_enter, in_break, line);
  modport engine (input  start, data, fmt_len, two_stop, par_on, par_bit, brk,
                  output ready, done, brk_enter, in_break, line);
endinterface : ulm_tx_if

// ===== hdl/ulm_tx_engine.sv
`timescale 1ns/10ps
module ulm_tx_engine (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  ulm_tx_if.engine tx
);
  ulm_pkg::ulm_tx_e state;
  logic [7:0]       shreg;
  logic [2:0]       bit_idx;
  logic             stop2;
  logic             par_q;
  logic             line_q;
  logic             done_q;

  // frame geometry and break entry at a bit boundary
  wire logic [2:0] last_idx = {1'b0, tx.fmt_len} + ulm_pkg::DATA_LAST_MIN;
  assign tx.brk_enter = tick & tx.brk & (state != ulm_pkg::TX_BRK);
  assign tx.ready     = (state == ulm_pkg::TX_IDLE) & ~tx.brk;
  assign tx.in_break  = (state == ulm_pkg::TX_BRK);
  assign tx.line      = line_q;
  assign tx.done      = done_q;

  // serialiser: start, data lsb first, parity, one or two stops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ulm_pkg::TX_IDLE;
      shreg   <= 8'h00;
      bit_idx <= 3'h0;
      stop2   <= 1'b0;
      par_q   <= 1'b0;
      line_q  <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tx.brk_enter) begin
        state  <= ulm_pkg::TX_BRK;  // shift register contents dropped
        line_q <= 1'b0;
      end else begin
        unique case (state)
          ulm_pkg::TX_IDLE: if (tx.start) begin
            shreg   <= tx.data;
            par_q   <= tx.par_bit;
            bit_idx <= 3'h0;
            line_q  <= 1'b0;
            state   <= ulm_pkg::TX_START;
          end
          ulm_pkg::TX_START: if (tick) begin
            line_q <= shreg[0];
            state  <= ulm_pkg::TX_DATA;
          end
          ulm_pkg::TX_DATA: if (tick) begin
            if (bit_idx == last_idx) begin
              if (tx.par_on) begin
                line_q <= par_q;
                state  <= ulm_pkg::TX_PAR;
              end else begin
                line_q <= 1'b1;
                stop2  <= tx.two_stop;
                state  <= ulm_pkg::TX_STOP;
              end
            end else begin
              line_q  <= shreg[1];
              shreg   <= {1'b0, shreg[7:1]};
              bit_idx <= bit_idx + 3'h1;
            end
          end
          ulm_pkg::TX_PAR: if (tick) begin
            line_q <= 1'b1;
            stop2  <= tx.two_stop;
            state  <= ulm_pkg::TX_STOP;
          end
          ulm_pkg::TX_STOP: if (tick) begin
            if (stop2) begin
              stop2 <= 1'b0;
            end else begin
              done_q <= 1'b1;
              state  <= ulm_pkg::TX_IDLE;
            end
          end
          ulm_pkg::TX_BRK: if (tick && !tx.brk) begin
            line_q <= 1'b1;  // recovery on the next baud edge
            state  <= ulm_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // break and parity timing checks
  a_break_entry_low: assert property (@(posedge clock) disable iff (!rst_n)
    tx.brk_enter |=> (state == ulm_pkg::TX_BRK) && !line_q)
    else $error("break entry did not drive the line low");
  a_break_resume_edge: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ulm_pkg::TX_BRK && tick && !tx.brk) |=> state == ulm_pkg::TX_IDLE && line_q)
    else $error("no recovery at the baud edge after break");
  a_parity_slot_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ulm_pkg::TX_PAR) |-> line_q == par_q)
    else $error("parity slot carries the wrong bit");
endmodule : ulm_tx_engine

// ===== test/ulm_peer.sv
`timescale 1ns/10ps
// serial peer on the line: one bit per clock, as the bench runs divisor 1
module ulm_peer (
  input  wire logic clock,
  input  wire logic txd,
  input  wire logic pol,
  output wire logic rxd
);
  logic lvl = 1'b1;
  wire  line = txd ^ pol;
  // both directions seen through the polarity control
  assign rxd = lvl ^ pol;

  // capture twelve bit times from the start edge, x if none comes
  task automatic grab(output logic [11:0] bits);
    bits = 'x;
    for (int k = 0; k < 400; k++) begin
      @(posedge clock);
      if (line === 1'b0) begin
        for (int j = 0; j < 12; j++) begin
          bits[j] = line;
          if (j < 11) @(posedge clock);
        end
        break;
      end
    end
  endtask : grab

  // send twelve bit times, padded with mark so the line ends idle
  task automatic send(input logic [11:0] bits);
    for (int k = 0; k < 12; k++) begin
      @(posedge clock);
      #1 lvl = bits[k];
    end
  endtask : send
endmodule : ulm_peer

// ===== test/ulm_line_modem_ctrl_tb.sv
`timescale 1ns/10ps
module ulm_line_modem_ctrl_tb;
  logic        clock, rst_n, io_wr, io_rd, pol, txd, rxd;
  logic        cts_n, dsr_n, dcd_n, ri_n, rts_n, dtr_n, aux_a_n, aux_b_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, v, d, lc;
  logic [11:0] got;
  int          miscompares, n_compared, seed, hi;

  ulm_line_modem_ctrl ulm_line_modem_ctrl_i (.clock(clock), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .txd(txd),
    .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .aux_a_n(aux_a_n), .aux_b_n(aux_b_n));
  ulm_peer ulm_peer_i (.clock(clock), .txd(txd), .pol(pol), .rxd(rxd));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one bus cycle; read data is taken the cycle after the strobe
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clock);
    #1 io_addr = a;
    io_wdata = wd;
    io_wr = w;
    io_rd = ~w;
    @(posedge clock);
    #1 io_wr = 1'b0;
    io_rd = 1'b0;
    rd = io_rdata;
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [7:0] wd);
    logic [7:0] x;
    acc(1'b1, a, wd, x);
  endtask : wr

  // polarity changes under loopback so the receiver never sees a false start edge
  task automatic setpol(input logic [7:0] m);
    wr(ulm_pkg::ADDR_MCTL, m | 8'h10);
    pol = m[ulm_pkg::MC_POL];
    wr(ulm_pkg::ADDR_MCTL, m);
  endtask : setpol

  // wait for the transmitter to go empty, bounded
  task automatic idle;
    logic [7:0] s;
    for (int k = 0; k < 100; k++) begin
      acc(1'b0, ulm_pkg::ADDR_LSR, 8'h00, s);
      if (s[ulm_pkg::LS_TEMT] === 1'b1) return;
    end
    miscompares++;
    test_done();
  endtask : idle

  // expected line bits: start, data lsb first, parity, then mark
  function automatic logic [11:0] frame(input logic [7:0] dd, input logic [7:0] c, input logic m);
    logic [11:0] f;
    logic        p;
    int          n;
    n = 5 + int'(c[1:0]);
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < n; k++) f[k+1] = dd[k];
    p = (m ? c[4] : ~((^(dd & (8'hff >> (8 - n)))) ^ c[4])) ^ c[5];
    if (c[3]) f[n+1] = p;
    return f;
  endfunction : frame

  initial begin
    seed = $urandom(51597);
    {rst_n, io_wr, io_rd, pol, io_addr, io_wdata} = '0;
    {cts_n, dsr_n, dcd_n, ri_n} = 4'hf;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    acc(1'b0, ulm_pkg::ADDR_LCTL, 8'h00, v);
    chk("line ctrl reset", 12'h000, v);
    chk("pins reset", 12'h01f, {txd, rts_n, dtr_n, aux_a_n, aux_b_n});
    $display("test reset done");
    wr(ulm_pkg::ADDR_LCTL, 8'h80);
    wr(ulm_pkg::ADDR_DATA, 8'h01);
    wr(ulm_pkg::ADDR_IER, 8'h00);
    acc(1'b0, ulm_pkg::ADDR_DATA, 8'h00, v);
    chk("divisor low", 12'h001, v);
    wr(ulm_pkg::ADDR_LCTL, 8'h00);
    wr(ulm_pkg::ADDR_IER, 8'h5a);
    wr(ulm_pkg::ADDR_LCTL, 8'h80);
    acc(1'b0, ulm_pkg::ADDR_IER, 8'h00, v);
    chk("divisor high", 12'h000, v);
    wr(ulm_pkg::ADDR_LCTL, 8'h00);
    acc(1'b0, ulm_pkg::ADDR_IER, 8'h00, v);
    chk("irq enable", 12'h05a, v);
    $display("test banking done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'h3f;
      lc = 8'($urandom) & 8'hbf;
      {cts_n, dsr_n, dcd_n, ri_n} = 4'($urandom);
      wr(ulm_pkg::ADDR_LCTL, lc);
      wr(ulm_pkg::ADDR_MCTL, v);
      acc(1'b0, ulm_pkg::ADDR_MCTL, 8'h00, d);
      chk("modem ctrl", v & 8'h7f, d);
      acc(1'b0, ulm_pkg::ADDR_LCTL, 8'h00, d);
      chk("line ctrl", lc, d);
      chk("modem pins", v[4] ? 5'h1f : {~v[1:0], 3'h7},
          {rts_n, dtr_n, aux_a_n, aux_b_n, txd});
      acc(1'b0, ulm_pkg::ADDR_MSR, 8'h00, d);
      chk("modem status", v[4] ? {v[3:2], v[0], v[1], 4'h0}
          : {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, 4'h0}, d);
    end
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      setpol({1'b0, 1'(i >= 8), 6'h00});
      lc = (8'($urandom) & 8'h38) | 8'(i % 8);
      wr(ulm_pkg::ADDR_LCTL, lc);
      chk("idle level", !pol, txd);
      d = 8'($urandom);
      fork
        ulm_peer_i.grab(got);
        wr(ulm_pkg::ADDR_DATA, d);
      join
      chk("tx frame", frame(d, lc, 1'b0), got);
      idle();
    end
    $display("test transmit done");
    for (int i = 0; i < 4; i++) begin
      setpol({1'b0, i[1], 6'h00});
      wr(ulm_pkg::ADDR_LCTL, 8'h0b);
      d = 8'($urandom);
      ulm_peer_i.send(frame(d, {2'b00, i[0], 5'h0b}, 1'b0));
      acc(1'b0, ulm_pkg::ADDR_DATA, 8'h00, v);
      chk("rx data", d, v);
      acc(1'b0, ulm_pkg::ADDR_LSR, 8'h00, v);
      chk("rx parity flag", i[0], v[ulm_pkg::LS_PE]);
    end
    $display("test receive done");
    setpol(8'h20);
    lc = 8'h1b;
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      fork
        ulm_peer_i.grab(got);
        begin
          wr(ulm_pkg::ADDR_LCTL, lc);
          wr(ulm_pkg::ADDR_DATA, d);
        end
      join
      chk("multidrop frame", frame(d, lc, 1'b1), got);
      idle();
      acc(1'b0, ulm_pkg::ADDR_LCTL, 8'h00, v);
      chk("parity select", 8'h0b, v);
      lc = 8'h0b;
    end
    ulm_peer_i.send(frame(d, 8'h1b, 1'b1));
    acc(1'b0, ulm_pkg::ADDR_LSR, 8'h00, v);
    chk("multidrop rx flag", 1'b1, v[ulm_pkg::LS_PE]);
    $display("test multidrop done");
    wr(ulm_pkg::ADDR_MCTL, 8'h00);
    wr(ulm_pkg::ADDR_LCTL, 8'h03);
    wr(ulm_pkg::ADDR_DATA, 8'h55);
    wr(ulm_pkg::ADDR_DATA, 8'haa);
    wr(ulm_pkg::ADDR_LCTL, 8'h43);
    repeat (3) @(posedge clock);
    chk("break line", 1'b0, txd);
    acc(1'b0, ulm_pkg::ADDR_LSR, 8'h00, v);
    chk("break flags", 2'b00, v[6:5]);
    wr(ulm_pkg::ADDR_LCTL, 8'h03);
    @(posedge clock);
    hi = 0;
    for (int k = 0; k < 30; k++) begin
      @(posedge clock);
      hi += int'(txd === 1'b1);
    end
    chk("after break", 12'd30, 12'(hi));
    acc(1'b0, ulm_pkg::ADDR_LSR, 8'h00, v);
    chk("flags after break", 2'b11, v[6:5]);
    d = 8'($urandom);
    fork
      ulm_peer_i.grab(got);
      wr(ulm_pkg::ADDR_DATA, d);
    join
    chk("frame after break", frame(d, 8'h03, 1'b0), got);
    idle();
    $display("test break done");
    wr(ulm_pkg::ADDR_MCTL, 8'h10);
    d = 8'($urandom);
    fork
      ulm_peer_i.send(frame(~d, 8'h03, 1'b0));
      wr(ulm_pkg::ADDR_DATA, d);
    join
    chk("loop txd", 1'b1, txd);
    idle();
    repeat (3) @(posedge clock);
    acc(1'b0, ulm_pkg::ADDR_DATA, 8'h00, v);
    chk("loop data", d, v);
    $display("test loopback done");
    test_done();
  end
endmodule : ulm_line_modem_ctrl_tb
